//--- logic/thcp_defs.vh
// Constants for the transmit channel provisioning block.
// Assumes inclusion by bare name from the logic/ folder.
`ifndef THCP_DEFS_VH
`define THCP_DEFS_VH
`define THCP_ADDR_W          10
`define THCP_OFF_SEL         10'h380
`define THCP_OFF_DATA_A      10'h384
`define THCP_OFF_DATA_B      10'h388
`define THCP_SEL_BUSY        15
`define THCP_SEL_DIR         14
`define THCP_SEL_LINK_SELECT_HI     4
`define THCP_A_SVC           15
`define THCP_A_CRC_HI        14
`define THCP_A_CRC_LO        13
`define THCP_A_IDLE          12
`define THCP_A_FRAME         11
`define THCP_PTR_HI          8
`define THCP_B_LSB_STUFF     15
`define THCP_B_EXP_INH       14
`define THCP_B_INVERT        13
`define THCP_B_FCS_INV       12
`define THCP_CRC_NONE        2'h0
`define THCP_CRC_CCITT       2'h1
`define THCP_CRC_32          2'h2
`define THCP_CRC_RSVD        2'h3
`define THCP_ENTRY_W         27
`define THCP_E_PTR_HI        8
`define THCP_E_FRAME         9
`define THCP_E_IDLE          10
`define THCP_E_CRC_LO        11
`define THCP_E_CRC_HI        12
`define THCP_E_SVC           13
`define THCP_E_LEN_LO        14
`define THCP_E_LEN_HI        22
`define THCP_E_FCS_INV       23
`define THCP_E_INVERT        24
`define THCP_E_EXP_INH       25
`define THCP_E_LSB_STUFF     26
`define THCP_CRC_INIT        32'hffffffff
`define THCP_ACCESS_CYCLES   2'h2
`define THCP_FLAG_BYTE       8'h7e
`define THCP_IDLE_BYTE       8'hff
`endif

//--- logic/thcp_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module thcp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clock,    // System clock
  input  wire             rst_n,    // Async reset, active low
  input  wire             in_valid, // Write request
  output wire             in_ready, // Not full
  input  wire [WIDTH-1:0] in_data,  // Write data
  output wire             out_valid,// Not empty
  input  wire             out_ready,// Read accept
  output wire [WIDTH-1:0] out_data  // Head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
      if (push & ~pop) cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // thcp_fifo

//--- logic/thcp_serializer.v
// Byte serializer: one channel's octets to a bit stream, LSB first.
// Assumes octets already carry flags and check fields.
`timescale 1ns/1ps
module thcp_serializer (
  input  wire       clock,       // System clock
  input  wire       rst_n,       // Async reset, active low
  input  wire       byte_valid,  // Octet available
  output wire       byte_ready,  // Octet taken
  input  wire [7:0] byte_data,   // Octet
  input  wire       lsb_stuff,   // Force last bit of octet
  input  wire       forced_lsb,  // Value of the forced bit
  input  wire       invert,      // Invert whole stream
  input  wire       bit_enable,  // Link wants a bit
  output reg        tx_bit_q,    // Serial data
  output reg        tx_valid_q   // Bit strobe
);
  reg [7:0] sh_q;
  reg [2:0] pos_q;
  reg       busy_q;
  wire      take;
  wire      out_bit;

  assign take       = bit_enable & byte_valid & (~busy_q | (pos_q == 3'h7));
  assign byte_ready = take;
  // Last bit of an octet may be replaced by a constant
  assign out_bit = (lsb_stuff && pos_q == 3'h7) ? forced_lsb : sh_q[0];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 8'h00; pos_q <= 3'h0; busy_q <= 1'b0;
      tx_bit_q <= 1'b0; tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= bit_enable & busy_q;
      if (bit_enable & busy_q) begin
        tx_bit_q <= out_bit ^ invert;
        sh_q     <= {1'b0, sh_q[7:1]};
        pos_q    <= pos_q + 3'h1;
        if (pos_q == 3'h7 && !take) busy_q <= 1'b0;
      end
      if (take) begin
        sh_q  <= byte_data;
        pos_q <= 3'h0;
        busy_q <= 1'b1;
      end
    end
  end
endmodule // thcp_serializer

//--- logic/thcp_top.v
// Transmit channel provisioning: indirect provision RAM access, plus a
// per-channel octet framer that applies the provisioned settings.
// Assumes a single-cycle register port and data requests from a link
// assigner naming a channel; bit-level stuffing is done downstream.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "thcp_defs.vh"
module thcp_top #(
  parameter CHANNELS = 32,
  parameter LINK_SELECT_W   = 5,
  parameter FIFO_DEP = 16,
  parameter FIFO_AW  = 4
) (
  input  wire                   clock,      // 200 MHz system clock
  input  wire                   rst_n,      // Async reset, active low
  input  wire [`THCP_ADDR_W-1:0] reg_addr,  // Register byte address
  input  wire [31:0]            reg_wdata,  // Write data
  input  wire                   reg_wr,     // Write strobe
  input  wire                   reg_rd,     // Read strobe
  output reg  [31:0]            reg_rdata_q,// Read data, next cycle
  input  wire                   req_valid,  // Data request from assigner
  input  wire [LINK_SELECT_W-1:0]      req_link_select,   // Requested channel
  input  wire                   pkt_valid,  // Packet octet offered
  output wire                   pkt_ready,  // Octet accepted into FIFO
  input  wire [7:0]             pkt_data,   // Packet octet
  input  wire                   pkt_last,   // Last octet of packet
  input  wire [LINK_SELECT_W-1:0]      pkt_link_select,   // Channel being framed
  input  wire                   bit_enable, // Link takes a bit
  output wire                   tx_bit,     // Serial data
  output wire                   tx_valid,   // Bit strobe
  output reg                    req_grant_q,// Request serviced
  output reg                    fifo_norm_q,// Normal DMA request
  output reg                    fifo_exp_q, // Expedited DMA request
  input  wire                   exp_need,   // FIFO wants expedite
  input  wire                   norm_need,  // FIFO wants normal
  output reg  [8:0]             cur_ptr_q,  // Block pointer of pkt_link_select
  output reg  [8:0]             cur_len_q,  // Block count minus one
  output reg  [1:0]             cur_crc_q   // Effective CRC mode
);
  ////////////////////////////////////////////////////////////////////
  // Register state and provision RAM
  reg [`THCP_ENTRY_W-1:0] channel_service_enable_ram [0:CHANNELS-1];
  reg [15:0]       data_a_q;
  reg [15:0]       data_b_q;
  reg [LINK_SELECT_W-1:0] link_select_q;
  reg              dir_q;
  reg              busy_q;
  reg [1:0]        acc_cnt_q;
  wire             sel_wr;
  wire             acc_done;
  wire [`THCP_ENTRY_W-1:0] entry_w;
  wire [`THCP_ENTRY_W-1:0] entry_r;
  integer i;

  // Entry: {data_b[15:12], len, data_a[15:11], ptr}
  function [`THCP_ENTRY_W-1:0] pack;
    input [15:0] a;
    input [15:0] b;
    pack = {b[15:12], b[`THCP_PTR_HI:0], a[15:11], a[`THCP_PTR_HI:0]};
  endfunction

  // Reserved code and unframed channels both give no check field
  function [1:0] eff_crc;
    input [`THCP_ENTRY_W-1:0] e;
    reg   [1:0] c;
    begin
      c = e[`THCP_E_CRC_HI:`THCP_E_CRC_LO];
      if (!e[`THCP_E_FRAME] || c == `THCP_CRC_RSVD)
        eff_crc = `THCP_CRC_NONE;
      else
        eff_crc = c;
    end
  endfunction

  assign sel_wr   = reg_wr && reg_addr == `THCP_OFF_SEL;
  assign acc_done = busy_q && acc_cnt_q == `THCP_ACCESS_CYCLES - 2'h1;
  assign entry_w  = pack(data_a_q, data_b_q);
  assign entry_r  = channel_service_enable_ram[link_select_q];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        channel_service_enable_ram[i] <= {`THCP_ENTRY_W{1'b0}};
      end
    end else if (acc_done && !dir_q) begin
      channel_service_enable_ram[link_select_q] <= entry_w;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_a_q  <= 16'h0000;
      data_b_q  <= 16'h0000;
      link_select_q    <= {LINK_SELECT_W{1'b0}};
      dir_q     <= 1'b0;
      busy_q    <= 1'b0;
      acc_cnt_q <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == `THCP_OFF_DATA_A && !busy_q)
        data_a_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `THCP_OFF_DATA_B && !busy_q)
        data_b_q <= reg_wdata[15:0];
      if (sel_wr && !busy_q) begin
        link_select_q    <= reg_wdata[LINK_SELECT_W-1:0];
        dir_q     <= reg_wdata[`THCP_SEL_DIR];
        busy_q    <= 1'b1;
        acc_cnt_q <= 2'h0;
      end else if (acc_done) begin
        busy_q <= 1'b0;
        if (dir_q) begin
          // Pointer and length stay as written: they are write-only
          data_a_q[15:11] <= entry_r[`THCP_E_SVC:`THCP_E_FRAME];
          data_b_q[15:12] <=
            entry_r[`THCP_E_LSB_STUFF:`THCP_E_FCS_INV];
        end
      end else if (busy_q) begin
        acc_cnt_q <= acc_cnt_q + 2'h1;
      end
    end
  end

  // Read data; write-only and unused bits read as zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) reg_rdata_q <= 32'h00000000;
    else if (reg_rd) begin
      case (reg_addr)
        `THCP_OFF_SEL:
          reg_rdata_q <= {16'h0000, busy_q, dir_q,
                          {(14-LINK_SELECT_W){1'b0}}, link_select_q};
        `THCP_OFF_DATA_A:
          reg_rdata_q <= {16'h0000, data_a_q[15:11], 11'h000};
        `THCP_OFF_DATA_B:
          reg_rdata_q <= {16'h0000, data_b_q[15:12], 12'h000};
        default: reg_rdata_q <= 32'h00000000;
      endcase
    end else reg_rdata_q <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////
  // Service, expedited DMA request gating and per-channel settings
  wire [`THCP_ENTRY_W-1:0] req_e;
  wire [`THCP_ENTRY_W-1:0] pk_e;
  assign req_e = channel_service_enable_ram[req_link_select];
  assign pk_e  = channel_service_enable_ram[pkt_link_select];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_grant_q <= 1'b0;
      fifo_norm_q <= 1'b0;
      fifo_exp_q  <= 1'b0;
      cur_ptr_q   <= 9'h000;
      cur_len_q   <= 9'h000;
      cur_crc_q   <= `THCP_CRC_NONE;
    end else begin
      req_grant_q <= req_valid & req_e[`THCP_E_SVC];
      fifo_norm_q <= norm_need;
      fifo_exp_q  <= exp_need & ~pk_e[`THCP_E_EXP_INH];
      cur_ptr_q   <= pk_e[`THCP_E_PTR_HI:0];
      cur_len_q   <= pk_e[`THCP_E_LEN_HI:`THCP_E_LEN_LO];
      cur_crc_q   <= eff_crc(pk_e);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Octet framer: flags, payload, FCS, fill
  localparam S_FILL = 2'h0;
  localparam S_DATA = 2'h1;
  localparam S_FCS  = 2'h2;
  localparam S_END  = 2'h3;
  reg  [1:0]  st_q;
  reg  [31:0] crc_q;
  reg  [1:0]  fcs_idx_q;
  reg  [7:0]  ob_d;
  reg         ob_v_d;
  reg         take_in;
  wire        framed;
  wire        fill_ones;
  wire        fcs_inv;
  wire [1:0]  crc_mode;
  wire [1:0]  fcs_len;
  wire        ff_valid;
  wire [7:0]  ff_data;
  wire [7:0]  fcs_byte;

  assign framed    = pk_e[`THCP_E_FRAME];
  assign fill_ones = pk_e[`THCP_E_IDLE];
  assign fcs_inv   = pk_e[`THCP_E_FCS_INV];
  assign crc_mode  = eff_crc(pk_e);
  assign fcs_len   = crc_mode == `THCP_CRC_32 ? 2'h3 : 2'h1;
  assign fcs_byte  = crc_q[8*fcs_idx_q +: 8] ^ {8{~fcs_inv}} ;

  // CRC update for one octet; polynomial picked by mode
  function [31:0] crc_step;
    input [31:0] c;
    input [7:0]  d;
    input        wide;
    integer k;
    reg [31:0] r;
    begin
      r = c;
      for (k = 0; k < 8; k = k + 1) begin
        if (wide)
          r = (r[0] ^ d[k]) ? (r >> 1) ^ 32'hedb88320 : r >> 1;
        else
          r = (r[0] ^ d[k]) ? {16'h0000, (r[15:0] >> 1) ^ 16'h8408}
                            : {16'h0000, r[15:0] >> 1};
      end
      crc_step = r;
    end
  endfunction

  always @* begin
    ob_d    = `THCP_FLAG_BYTE;
    ob_v_d  = 1'b0;
    take_in = 1'b0;
    case (st_q)
      S_FILL: begin
        ob_v_d = 1'b1;
        if (!framed) begin
          ob_d    = ff_data;
          ob_v_d  = ff_valid;
          take_in = 1'b1;
        end else if (ff_valid) ob_d = `THCP_FLAG_BYTE;
        else ob_d = fill_ones ? `THCP_IDLE_BYTE : `THCP_FLAG_BYTE;
      end
      S_DATA: begin
        ob_d    = ff_data;
        ob_v_d  = ff_valid;
        take_in = 1'b1;
      end
      S_FCS: begin ob_d = fcs_byte; ob_v_d = 1'b1; end
      S_END: begin ob_d = `THCP_FLAG_BYTE; ob_v_d = 1'b1; end
      default: begin ob_d = `THCP_FLAG_BYTE; ob_v_d = 1'b0; end
    endcase
  end

  wire ser_ready;
  wire adv;
  wire ff_last;
  assign adv = ob_v_d & ser_ready;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= S_FILL;
      crc_q     <= `THCP_CRC_INIT;
      fcs_idx_q <= 2'h0;
    end else if (adv) begin
      case (st_q)
        S_FILL: if (framed && ff_valid) begin
          st_q <= S_DATA; crc_q <= 32'hffffffff;
        end
        S_DATA: begin
          crc_q <= crc_step(crc_q, ff_data, crc_mode == `THCP_CRC_32);
          if (ff_last) begin
            fcs_idx_q <= 2'h0;
            st_q <= (crc_mode == `THCP_CRC_NONE) ? S_END : S_FCS;
          end
        end
        S_FCS: begin
          fcs_idx_q <= fcs_idx_q + 2'h1;
          if (fcs_idx_q == fcs_len) st_q <= S_END;
        end
        S_END: st_q <= S_FILL;
        default: st_q <= S_FILL;
      endcase
    end
  end

  wire [8:0] ff_word;

  thcp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEP), .AW(FIFO_AW)) u_fifo (
    .clock    (clock),
    .rst_n    (rst_n),
    .in_valid (pkt_valid),
    .in_ready (pkt_ready),
    .in_data  ({pkt_last, pkt_data}),
    .out_valid(ff_valid),
    .out_ready(take_in & ser_ready),
    .out_data (ff_word)
  );
  assign ff_data = ff_word[7:0];
  assign ff_last = ff_word[8];

  thcp_serializer u_ser (
    .clock     (clock),
    .rst_n     (rst_n),
    .byte_valid(ob_v_d),
    .byte_ready(ser_ready),
    .byte_data (ob_d),
    .lsb_stuff (pk_e[`THCP_E_LSB_STUFF]),
    .forced_lsb(1'b0),
    .invert    (pk_e[`THCP_E_INVERT]),
    .bit_enable(bit_enable),
    .tx_bit_q  (tx_bit),
    .tx_valid_q(tx_valid)
  );
endmodule // thcp_top

//--- tb/thcp_top_sva.sv
// Port-level assertions for the transmit channel provisioning block.
// Assumes the shared defines header and a bind onto thcp_top.
`timescale 1ns/1ps
`include "thcp_defs.vh"
module thcp_top_sva (
  input wire logic                    clock,       // System clock
  input wire logic                    rst_n,       // Async reset, low
  input wire logic [`THCP_ADDR_W-1:0] reg_addr,    // Register address
  input wire logic                    reg_wr,      // Write strobe
  input wire logic                    reg_rd,      // Read strobe
  input wire logic [31:0]             reg_rdata_q, // Read data
  input wire logic                    req_valid,   // Assigner request
  input wire logic                    req_grant_q, // Request serviced
  input wire logic                    norm_need,   // Normal wanted
  input wire logic                    exp_need,    // Expedite wanted
  input wire logic                    fifo_norm_q, // Normal request
  input wire logic                    fifo_exp_q,  // Expedited request
  input wire logic [1:0]              cur_crc_q    // Effective CRC mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  wire sel_wr = reg_wr && reg_addr == `THCP_OFF_SEL;
  wire sel_rd = reg_rd && reg_addr == `THCP_OFF_SEL;
  wire dat_rd = reg_rd && (reg_addr == `THCP_OFF_DATA_A ||
                           reg_addr == `THCP_OFF_DATA_B);

  ////////////////////////////////////////////////////////////////////////
  // Trigger then status read with no gap, and after the access time
  sequence trig_s;
    sel_wr ##1 sel_rd;
  endsequence
  sequence done_s;
    sel_wr ##1 !sel_wr [*2] ##1 sel_rd;
  endsequence

  busy_set_a: assert property (trig_s |=> reg_rdata_q[15])
    else $error("busy not seen right after trigger");
  busy_clear_a: assert property (done_s |=> !reg_rdata_q[15])
    else $error("busy still set after access time");
  write_only_a: assert property (dat_rd |=> reg_rdata_q[8:0] == 9'h0)
    else $error("pointer or length field readable");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
    else $error("read data outside read slot");
  grant_cause_a: assert property (!req_valid |=> !req_grant_q)
    else $error("grant without request");
  exp_cause_a: assert property (!exp_need |=> !fifo_exp_q)
    else $error("expedite without need");
  norm_cause_a: assert property (!norm_need |=> !fifo_norm_q)
    else $error("normal request without need");
  crc_rsvd_a: assert property (cur_crc_q != `THCP_CRC_RSVD)
    else $error("reserved crc mode applied");
endmodule // thcp_top_sva

bind thcp_top thcp_top_sva u_sva (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .req_valid(req_valid),
  .req_grant_q(req_grant_q), .norm_need(norm_need), .exp_need(exp_need),
  .fifo_norm_q(fifo_norm_q), .fifo_exp_q(fifo_exp_q),
  .cur_crc_q(cur_crc_q)
);

//--- tb/thcp_top_tb.sv
// Self-checking bench for the transmit channel provisioning block.
// Assumes the design files and the bound checker are compiled first.
`timescale 1ns/1ps
`include "thcp_defs.vh"
module thcp_top_tb;
  reg         clock, rst_n, reg_wr, reg_rd, req_valid, pkt_valid;
  reg         pkt_last, bit_enable, exp_need, norm_need;
  reg  [9:0]  reg_addr;
  reg  [31:0] reg_wdata, v;
  reg  [4:0]  req_link_select, pkt_link_select;
  reg  [7:0]  pkt_data;
  wire [31:0] reg_rdata_q;
  wire [8:0]  cur_ptr_q, cur_len_q;
  wire [1:0]  cur_crc_q;
  wire        pkt_ready, tx_bit, tx_valid;
  wire        req_grant_q, fifo_norm_q, fifo_exp_q;
  integer     fail_count, n_checks, i, k, n;
  reg  [4:0]  ch [0:3];
  reg  [31:0] ta [0:3];
  reg  [31:0] tb [0:3];

  thcp_top u_dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .req_valid(req_valid),
    .req_link_select(req_link_select), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_link_select(pkt_link_select),
    .bit_enable(bit_enable), .tx_bit(tx_bit), .tx_valid(tx_valid),
    .req_grant_q(req_grant_q), .fifo_norm_q(fifo_norm_q),
    .fifo_exp_q(fifo_exp_q), .exp_need(exp_need), .norm_need(norm_need),
    .cur_ptr_q(cur_ptr_q), .cur_len_q(cur_len_q), .cur_crc_q(cur_crc_q)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input [9:0] a, input [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task rd(input [9:0] a, output [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask

  // Select write with an immediate status read, then poll to idle
  task trig(input [31:0] d);
    @(posedge clock);
    reg_addr  <= `THCP_OFF_SEL;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q[15], 1);
    n = 0;
    v = 32'h8000;
    while (v[15] && n < 20) begin
      rd(`THCP_OFF_SEL, v);
      n = n + 1;
    end
    chk(n, 1);
    chk(v & 32'hc01f, d);
  endtask

  // Count ones over nb strobed bits, giving up after 400 clocks
  task count_ones(input integer nb, output integer cnt);
    integer m, j;
    begin
      cnt = 0;
      m = 0;
      j = 0;
      while (m < nb && j < 400) begin
        @(posedge clock);
        #1;
        if (tx_valid === 1'b1) begin
          m = m + 1;
          cnt = cnt + (tx_bit === 1'b1);
        end
        j = j + 1;
      end
    end
  endtask

  task close_out;
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count = fail_count + 1;
    close_out;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    n_checks = 0;
    {rst_n, reg_wr, reg_rd, req_valid, pkt_valid, pkt_last} = 6'h0;
    {bit_enable, exp_need, norm_need} = 3'h0;
    reg_addr = 10'h0;
    reg_wdata = 32'h0;
    req_link_select = 5'h0;
    pkt_link_select = 5'h0;
    pkt_data = 8'h0;
    ch[0] = 5'h03;
    ch[1] = 5'h05;
    ch[2] = 5'h07;
    ch[3] = 5'h09;
    ta[0] = 32'hb955;
    ta[1] = 32'h69ff;
    ta[2] = 32'hc010;
    ta[3] = 32'h4800;
    tb[0] = 32'hd0aa;
    tb[1] = 32'h0003;
    tb[2] = 32'h200f;
    tb[3] = 32'h0000;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(`THCP_OFF_SEL, v);
    chk(v, 0);
    rd(`THCP_OFF_DATA_A, v);
    chk(v, 0);
    rd(10'h3fc, v);
    chk(v, 0);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`THCP_OFF_DATA_A, ta[i]);
      wr(`THCP_OFF_DATA_B, tb[i]);
      rd(`THCP_OFF_DATA_A, v);
      chk(v, ta[i] & 32'hf800);
      rd(`THCP_OFF_DATA_B, v);
      chk(v, tb[i] & 32'hf000);
      trig({27'h0, ch[i]});
    end
    wr(`THCP_OFF_DATA_A, 32'hffffffff);
    wr(`THCP_OFF_DATA_B, 32'hffffffff);
    for (i = 0; i < 4; i = i + 1) begin
      trig({17'h0, 1'b1, 9'h0, ch[i]});
      rd(`THCP_OFF_DATA_A, v);
      chk(v, ta[i] & 32'hf800);
      rd(`THCP_OFF_DATA_B, v);
      chk(v, tb[i] & 32'hf000);
    end
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clock);
      pkt_link_select  <= ch[i];
      req_link_select  <= ch[i];
      req_valid <= 1'b1;
      exp_need  <= 1'b1;
      norm_need <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk(cur_ptr_q, ta[i][8:0]);
      chk(cur_len_q, tb[i][8:0]);
      chk(cur_crc_q, (ta[i][11] && ta[i][14:13] != 2'h3) ?
          ta[i][14:13] : 2'h0);
      chk(req_grant_q, ta[i][15]);
      chk(fifo_exp_q, !tb[i][14]);
      chk(fifo_norm_q, 1);
    end
    // Channel 7 runs unframed and inverted: zero octets leave as ones
    @(posedge clock);
    req_valid <= 1'b0;
    exp_need  <= 1'b0;
    norm_need <= 1'b0;
    pkt_link_select  <= 5'h07;
    pkt_valid <= 1'b1;
    n = 0;
    repeat (40) begin
      #1;
      if (pkt_ready === 1'b1)
        n = n + 1;
      @(posedge clock);
    end
    pkt_valid <= 1'b0;
    chk(n, 16);
    bit_enable <= 1'b1;
    count_ones(32, k);
    chk(k, 32);
    chk(pkt_ready, 1);
    // Drained, channel 3 idles on ones with each octet's last bit forced
    repeat (150) @(posedge clock);
    pkt_link_select <= 5'h03;
    count_ones(16, k);
    count_ones(64, k);
    chk(k, 56);
    // Channel 9 fills with flags: six ones per octet at any alignment
    @(posedge clock);
    pkt_link_select <= 5'h09;
    count_ones(16, k);
    count_ones(64, k);
    chk(k, 48);
    close_out;
  end
endmodule // thcp_top_tb
